/* File: common/edit_pkg.sv */
// Shared constants and types for the reference memory edit engine.
package edit_pkg;
  localparam int DEPTH_DEF = 16384;
  localparam int CHANS_DEF = 32;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int VAL_W = 16;
  // Register byte offsets.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_CHAN = 8'h08;
  localparam logic [7:0] REG_ENTRY = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_LINE = 8'h14;
  localparam logic [7:0] REG_ROLL = 8'h18;
  localparam logic [7:0] REG_DELAY = 8'h1C;
  localparam logic [7:0] REG_MADDR = 8'h20;
  localparam logic [7:0] REG_MDATA = 8'h24;
  localparam logic [7:0] REG_MWMASK = 8'h28;
  localparam logic [7:0] REG_MBMASK = 8'h2C;
  localparam logic [7:0] REG_DUP_BASE = 8'h40;
  // Field positions.
  localparam int CTRL_EXEC = 0;
  localparam int CTRL_EXIT = 1;
  localparam int CTRL_CMPMODE = 2;
  localparam int CHAN_SRC_LSB = 0;
  localparam int CHAN_DST_LSB = 8;
  localparam int ENTRY_KIND_LSB = 16;
  localparam int OP_W = 5;
  localparam int ST_BUSY = 0;
  localparam int ST_PEND = 1;
  localparam int ST_ERR = 2;
  localparam int ST_CMPMODE = 3;
  localparam int ST_POP_LSB = 8;
  localparam int ST_COP_LSB = 16;
  localparam logic [1:0] PH_LAST = 2'h2;
  // Least trigger delay in compare mode and in analysis mode.
  localparam logic [15:0] DELAY_MIN_CMP = 16'h0001;
  localparam logic [15:0] DELAY_MIN_ANA = 16'h0000;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00, OP_GCLR = 5'h01, OP_GSET = 5'h02,
    OP_WMCLR = 5'h03, OP_WMSET = 5'h04, OP_BMCLR = 5'h05,
    OP_BMSET = 5'h06, OP_CCLR = 5'h07, OP_CSET = 5'h08,
    OP_CMCLR = 5'h09, OP_CMSET = 5'h0A, OP_COPY = 5'h0B,
    OP_XCHG = 5'h0C, OP_INS = 5'h0D, OP_DEL = 5'h0E,
    OP_RDN = 5'h0F, OP_RUP = 5'h10
  } op_t;
  localparam logic [4:0] OP_MAX = 5'h10;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_WALK = 3'b001, S_INS = 3'b010,
    S_DEL = 3'b011, S_REV = 3'b100
  } state_t;

  typedef enum logic [1:0] {
    ENT_LINE = 2'b00, ENT_ROLL = 2'b01, ENT_DELAY = 2'b10
  } entry_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;
endpackage

/* File: dv/ref_mem_editor_assertions.sv */
// Port-level checker for the reference memory editor, bound to its top.
`timescale 1ns/1ps
`default_nettype none
module edit_checker #(
  parameter int DEPTH = 16384,
  parameter int CH = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire edit_pkg::bus_req_t bus,
  input wire logic cmp_valid,
  input wire logic cmp_done,
  input wire logic cmp_mismatch,
  input wire logic busy,
  input wire logic entry_range_error
);
  import edit_pkg::*;
  localparam int BUSY_MAX = 4 * DEPTH + 8;
  logic ctrl_wr;
  logic line_wr;
  int busy_cnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Decoded writes; entry writes count only while idle.
  assign ctrl_wr = bus.wr && bus.addr == REG_CTRL;
  assign line_wr = bus.wr && bus.addr == REG_ENTRY && !busy
    && bus.wdata[17:16] == 2'h0;

  // Counts how long the current edit has kept busy high.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy ? busy_cnt + 1 : 0;
    end
  end

  property p_busy_start;
    $rose(busy) |-> $past(ctrl_wr) && $past(bus.wdata[CTRL_EXEC]);
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy rose without an execute write");
  property p_exit;
    ctrl_wr && bus.wdata[CTRL_EXIT] && !busy |=> !busy [*2];
  endproperty
  a_exit: assert property (p_exit)
    else $error("edit started although exit was given");
  property p_busy_max;
    busy |-> busy_cnt < BUSY_MAX;
  endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("busy held far too long");
  property p_err_bad;
    line_wr && bus.wdata[15:0] >= DEPTH |-> ##[1:2] entry_range_error;
  endproperty
  a_err_bad: assert property (p_err_bad)
    else $error("out of range line entry not flagged");
  property p_err_good;
    line_wr && bus.wdata[15:0] < DEPTH |=> ##[0:1] !entry_range_error;
  endproperty
  a_err_good: assert property (p_err_good)
    else $error("good line entry left the range error set");
  property p_err_hold;
    entry_range_error && !bus.wr && !$past(bus.wr) |=> entry_range_error;
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("range error dropped without a write");
  property p_done;
    cmp_valid |=> cmp_done;
  endproperty
  a_done: assert property (p_done)
    else $error("compare sample not answered");
  property p_quiet;
    !cmp_valid |=> !cmp_done && !cmp_mismatch;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("compare result without a sample");
endmodule
bind ref_mem_editor edit_checker #(.DEPTH(DEPTH), .CH(CH)) edit_checker_inst (
  .clk(clk), .rstn(rstn), .bus(bus), .cmp_valid(cmp_valid),
  .cmp_done(cmp_done), .cmp_mismatch(cmp_mismatch), .busy(busy),
  .entry_range_error(entry_range_error)
);
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking testbench for the reference memory editor.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import edit_pkg::*;
  localparam int D = 16;
  localparam int AW = $clog2(D);
  logic clk = 1'b0;
  logic rstn = 1'b0;
  bus_req_t bus = '0;
  logic [DATA_W-1:0] rdata;
  logic cmp_valid = 1'b0;
  logic [AW-1:0] cmp_addr = '0;
  logic [31:0] cmp_data = '0;
  logic cmp_done;
  logic cmp_mismatch;
  logic busy;
  logic entry_range_error;
  logic [31:0] exp_mem [D];
  logic [31:0] tmp [D];
  logic [31:0] got;
  int failures = 0;
  int n_tests = 0;

  ref_mem_editor #(.DEPTH(D), .CH(32)) ref_mem_editor_inst (
    .clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .cmp_valid(cmp_valid), .cmp_addr(cmp_addr), .cmp_data(cmp_data),
    .cmp_done(cmp_done), .cmp_mismatch(cmp_mismatch), .busy(busy),
    .entry_range_error(entry_range_error)
  );

  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] w);
    n_tests++;
    if (g !== w) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, g, w);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] g);
    @(posedge clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    g = rdata;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    #1;
    while (busy !== 1'b0 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({31'h0, busy}, 32'h0);
  endtask

  task automatic run(input op_t op);
    wr(REG_CMD, {27'h0, op});
    wr(REG_CTRL, 32'h0000_0001);
    wait_idle();
  endtask

  // Reads one register at every address and compares with the model, or with k when use_exp is low.
  task automatic scan(input logic [7:0] r, input logic use_exp,
                      input logic [31:0] k);
    logic [31:0] g;
    for (int a = 0; a < D; a++) begin
      wr(REG_MADDR, 32'(a));
      rd(r, g);
      check(g, use_exp ? exp_mem[a] : k);
    end
  endtask

  task automatic set_bit(input int ch, input logic v);
    for (int a = 0; a < D; a++) begin
      exp_mem[a][ch] = v;
    end
  endtask

  task automatic swap(input int x, input int y);
    logic b;
    for (int a = 0; a < D; a++) begin
      b = exp_mem[a][x];
      exp_mem[a][x] = exp_mem[a][y];
      exp_mem[a][y] = b;
    end
  endtask

  task automatic cmp(input int a, input logic [31:0] d, input logic m);
    @(posedge clk);
    cmp_valid <= 1'b1;
    cmp_addr <= a[AW-1:0];
    cmp_data <= d;
    @(posedge clk);
    cmp_valid <= 1'b0;
    #1;
    check({30'h0, cmp_done, cmp_mismatch}, {30'h0, 1'b1, m});
  endtask

  // Watchdog that cuts a hang short.
  initial begin
    #100000;
    failures++;
    print_verdict();
  end

  // Main sequence of editing scenarios.
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(REG_DELAY, got);
    check(got, 32'h0000_0001);
    for (int a = 0; a < D; a++) begin
      exp_mem[a] = 32'h5A00_00F0 ^ (32'(a) * 32'h0001_0203);
      wr(REG_MADDR, 32'(a));
      wr(REG_MDATA, exp_mem[a]);
    end
    wr(REG_CMD, {27'h0, OP_GCLR});
    wr(REG_CTRL, 32'h0000_0003);
    wr(REG_CTRL, 32'h0000_0001);
    wait_idle();
    scan(REG_MDATA, 1'b1, '0);
    wr(REG_CHAN, 32'h0000_0003);
    wr(REG_DUP_BASE + 8'h24, 32'h0000_0003);
    run(OP_CSET);
    set_bit(3, 1'b1);
    set_bit(9, 1'b1);
    scan(REG_MDATA, 1'b1, '0);
    wr(REG_DUP_BASE + 8'h24, 32'h0000_0009);
    wr(REG_CHAN, 32'h0000_0005);
    run(OP_CCLR);
    set_bit(5, 1'b0);
    scan(REG_MDATA, 1'b1, '0);
    wr(REG_CHAN, 32'h0000_0701);
    run(OP_COPY);
    for (int a = 0; a < D; a++) begin
      exp_mem[a][7] = exp_mem[a][1];
    end
    scan(REG_MDATA, 1'b1, '0);
    wr(REG_CHAN, 32'h0000_0402);
    run(OP_XCHG);
    swap(2, 4);
    scan(REG_MDATA, 1'b1, '0);
    run(OP_XCHG);
    swap(2, 4);
    scan(REG_MDATA, 1'b1, '0);
    wr(REG_CHAN, 32'h0000_0006);
    run(OP_CMSET);
    scan(REG_MBMASK, 1'b0, 32'h0000_0040);
    run(OP_CMCLR);
    scan(REG_MBMASK, 1'b0, 32'h0000_0000);
    scan(REG_MDATA, 1'b1, '0);
    run(OP_BMSET);
    scan(REG_MBMASK, 1'b0, 32'hFFFF_FFFF);
    cmp(2, ~exp_mem[2], 1'b0);
    run(OP_BMCLR);
    cmp(2, ~exp_mem[2], 1'b1);
    cmp(2, exp_mem[2], 1'b0);
    run(OP_WMSET);
    scan(REG_MWMASK, 1'b0, 32'h0000_0001);
    cmp(2, ~exp_mem[2], 1'b0);
    run(OP_WMCLR);
    scan(REG_MWMASK, 1'b0, 32'h0000_0000);
    wr(REG_ENTRY, 32'h0000_0004);
    run(OP_INS);
    for (int a = D - 1; a > 4; a--) begin
      exp_mem[a] = exp_mem[a - 1];
    end
    exp_mem[4] = '0;
    scan(REG_MDATA, 1'b1, '0);
    run(OP_DEL);
    for (int a = 4; a < D - 1; a++) begin
      exp_mem[a] = exp_mem[a + 1];
    end
    exp_mem[D - 1] = '0;
    scan(REG_MDATA, 1'b1, '0);
    wr(REG_ENTRY, 32'h0001_0003);
    run(OP_RDN);
    tmp = exp_mem;
    for (int a = 0; a < D; a++) begin
      exp_mem[(a + 3) % D] = tmp[a];
    end
    scan(REG_MDATA, 1'b1, '0);
    run(OP_RUP);
    exp_mem = tmp;
    scan(REG_MDATA, 1'b1, '0);
    wr(REG_ENTRY, 32'(D));
    rd(REG_LINE, got);
    check({got[30:0], entry_range_error}, 32'h0000_0009);
    wr(REG_ENTRY, 32'(D - 1));
    rd(REG_LINE, got);
    check({got[30:0], entry_range_error}, 32'(2 * (D - 1)));
    wr(REG_ENTRY, 32'h0002_0000);
    rd(REG_DELAY, got);
    check({got[30:0], entry_range_error}, 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_0004);
    wr(REG_ENTRY, 32'h0002_0000);
    rd(REG_DELAY, got);
    check({got[30:0], entry_range_error}, 32'h0000_0001);
    wr(REG_CTRL, 32'h0000_0000);
    wr(REG_CMD, {27'h0, OP_GSET});
    wr(REG_CTRL, 32'h0000_0001);
    rd(REG_STATUS, got);
    check({31'h0, got[ST_BUSY]}, 32'h0000_0001);
    wr(REG_CMD, {27'h0, OP_GCLR});
    wait_idle();
    wr(REG_CTRL, 32'h0000_0001);
    wait_idle();
    scan(REG_MDATA, 1'b0, 32'hFFFF_FFFF);
    run(OP_GCLR);
    scan(REG_MDATA, 1'b0, 32'h0000_0000);
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: logic/ref_mem_editor.sv */
// Edit engine for the analyzer reference memory with its register port.
//
// How it works
// - Global bit-mask set marks every bit mask flag at every address.
// - Global clear writes zero to all data at all addresses.
// - Global set writes one to all data at all addresses.
// - Edits run only after execute; exit first drops the pending edit.
// - Channel edits cover the selected channel at every address.
// - Channel clear zeroes the chosen channel and its duplicates, everywhere.
// - Channel set writes one to the chosen channel and its duplicates, everywhere.
// - Channel clear, set and mask edits reach every duplicate of the selected channel too; copy and exchange do not.
// - Channel mask clear removes only mask flags; stored data reappears.
// - Channel mask set masks the chosen channel at every address.
// - Copy duplicates the source channel into destination at all addresses.
// - Exchange swaps two channels completely at every address.
// - Repeating an exchange puts both channels back.
// - Insert writes a zero word at the address and shifts later words up.
// - Insert discards the word held at the last address.
// - Delete removes the word and shifts later words down.
// - Delete fills the last address with a zero word.
// - Roll down moves the word at zero to the entered address.
// - Roll up moves the word at the entered address to zero.
// - Both rolls are circular, so no word is lost.
// - Trigger delay may be zero in analysis mode, least one in compare.
// - Line address and roll amount entries are checked against the range.
// - A bad entry raises the range error and keeps the old value.
// - Masked bits and words never produce a compare mismatch.
`timescale 1ns/1ps
`default_nettype none
module ref_mem_editor #(
  parameter int DEPTH = edit_pkg::DEPTH_DEF,
  parameter int CH = edit_pkg::CHANS_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire edit_pkg::bus_req_t bus,
  output logic [edit_pkg::DATA_W-1:0] rdata,
  input wire logic cmp_valid,
  input wire logic [$clog2(DEPTH)-1:0] cmp_addr,
  input wire logic [CH-1:0] cmp_data,
  output logic cmp_done,
  output logic cmp_mismatch,
  output logic busy,
  output logic entry_range_error
);
  import edit_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(CH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW-1:0] ONE_A = AW'(1);
  localparam logic [VAL_W-1:0] LAST_V = VAL_W'(DEPTH - 1);
  logic [CH-1:0] data_mem [DEPTH];
  logic [CH-1:0] bmask_mem [DEPTH];
  logic wmask_mem [DEPTH];
  logic [CW-1:0] dup_of [CH];
  logic [CH-1:0] chan_set;
  state_t state;
  op_t op, pend_op;
  logic pend_valid, cmp_mode, wr_ctrl, start, entry_ok;
  logic [AW-1:0] idx, hi, line_a, roll_a, maddr;
  logic [1:0] phase;
  logic [VAL_W-1:0] trig_delay, ent_val, ent_min;
  logic [CW-1:0] src_ch, dst_ch;
  entry_t ent_kind;
  logic [ADDR_W-3:0] dup_idx;
  // Range of one reversal pass; a rotation is three reversals.
  function automatic logic [2*AW-1:0] rev_range(input logic up,
      input logic [1:0] ph, input logic [AW-1:0] k);
    logic [1:0] seg;
    seg = up ? ph : ((ph == 2'h0) ? PH_LAST : ph - 2'h1);
    case (seg)
      2'h0: rev_range = {{AW{1'b0}}, k - ONE_A};
      2'h1: rev_range = {k, LAST};
      default: rev_range = {{AW{1'b0}}, LAST};
    endcase
  endfunction
  // Every channel that shares the source copy of the selected one.
  always_comb begin
    chan_set = '0;
    for (int c = 0; c < CH; c++) begin
      if (dup_of[c] == dup_of[src_ch]) begin
        chan_set[c] = 1'b1;
      end
    end
  end
  // Command decode and entry range check.
  always_comb begin
    wr_ctrl = bus.wr && (bus.addr == REG_CTRL);
    start = wr_ctrl && bus.wdata[CTRL_EXEC] && !bus.wdata[CTRL_EXIT]
            && pend_valid && !busy;
    ent_val = bus.wdata[VAL_W-1:0];
    ent_kind = entry_t'(bus.wdata[ENTRY_KIND_LSB +: 2]);
    ent_min = (ent_kind == ENT_DELAY && cmp_mode) ? DELAY_MIN_CMP
              : DELAY_MIN_ANA;
    entry_ok = (ent_val >= ent_min) && (ent_val <= LAST_V);
    dup_idx = bus.addr[ADDR_W-1:2] - REG_DUP_BASE[ADDR_W-1:2];
  end
  // Pending command, acknowledge and exit handling.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_valid <= 1'b0;
      pend_op <= OP_NONE;
      cmp_mode <= 1'b0;
    end else begin
      if (bus.wr && bus.addr == REG_CMD && !busy
          && bus.wdata[OP_W-1:0] != OP_NONE
          && bus.wdata[OP_W-1:0] <= OP_MAX) begin
        pend_valid <= 1'b1;
        pend_op <= op_t'(bus.wdata[OP_W-1:0]);
      end
      if (wr_ctrl) begin
        cmp_mode <= bus.wdata[CTRL_CMPMODE];
        if (bus.wdata[CTRL_EXIT] || start) begin
          pend_valid <= 1'b0;
        end
      end
    end
  end
  // Entered values; a bad entry leaves the old value in place.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_a <= '0;
      roll_a <= '0;
      trig_delay <= DELAY_MIN_CMP;
      entry_range_error <= 1'b0;
    end else if (bus.wr && bus.addr == REG_ENTRY && !busy) begin
      entry_range_error <= !entry_ok;
      if (entry_ok) begin
        case (ent_kind)
          ENT_LINE: line_a <= ent_val[AW-1:0];
          ENT_ROLL: roll_a <= ent_val[AW-1:0];
          ENT_DELAY: trig_delay <= ent_val;
          default: ;
        endcase
      end
    end else if (wr_ctrl && bus.wdata[CTRL_EXIT]) begin
      entry_range_error <= 1'b0;
    end
  end
  // Channel selection, duplicate map and memory read pointer.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      src_ch <= '0;
      dst_ch <= '0;
      maddr <= '0;
      for (int c = 0; c < CH; c++) begin
        dup_of[c] <= CW'(c);
      end
    end else if (bus.wr && !busy) begin
      if (bus.addr == REG_CHAN) begin
        src_ch <= bus.wdata[CHAN_SRC_LSB +: CW];
        dst_ch <= bus.wdata[CHAN_DST_LSB +: CW];
      end
      if (bus.addr == REG_MADDR) begin
        maddr <= bus.wdata[AW-1:0];
      end
      if (bus.addr >= REG_DUP_BASE && int'(dup_idx) < CH) begin
        dup_of[dup_idx[CW-1:0]] <= bus.wdata[CW-1:0];
      end
    end
  end
  // Sequencer: walks every address the current edit touches.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= S_IDLE;
      op <= OP_NONE;
      busy <= 1'b0;
      idx <= '0;
      hi <= '0;
      phase <= '0;
    end else begin
      case (state)
        S_IDLE: begin
          if (start) begin
            op <= pend_op;
            busy <= 1'b1;
            phase <= '0;
            case (pend_op)
              OP_INS: begin
                state <= S_INS;
                idx <= LAST;
              end
              OP_DEL: begin
                state <= S_DEL;
                idx <= line_a;
              end
              OP_RDN, OP_RUP: begin
                if (roll_a == '0) begin
                  busy <= 1'b0;
                end else begin
                  state <= S_REV;
                  {idx, hi} <= rev_range(pend_op == OP_RUP, 2'h0, roll_a);
                end
              end
              default: begin
                state <= S_WALK;
                idx <= '0;
              end
            endcase
          end
        end
        S_WALK, S_DEL: begin
          if (idx == LAST) begin
            state <= S_IDLE;
            busy <= 1'b0;
          end else begin
            idx <= idx + ONE_A;
          end
        end
        S_INS: begin
          if (idx == line_a) begin
            state <= S_IDLE;
            busy <= 1'b0;
          end else begin
            idx <= idx - ONE_A;
          end
        end
        S_REV: begin
          if (idx < hi) begin
            idx <= idx + ONE_A;
            hi <= hi - ONE_A;
          end else if (phase == PH_LAST) begin
            state <= S_IDLE;
            busy <= 1'b0;
          end else begin
            phase <= phase + 2'h1;
            {idx, hi} <= rev_range(op == OP_RUP, phase + 2'h1, roll_a);
          end
        end
        default: begin
          state <= S_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end
  // Memory writes; one word (or one swapped pair) per cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int a = 0; a < DEPTH; a++) begin
        data_mem[a] <= '0;
        bmask_mem[a] <= '0;
        wmask_mem[a] <= 1'b0;
      end
    end else begin
      case (state)
        S_WALK: begin
          case (op)
            OP_GCLR: data_mem[idx] <= '0;
            OP_GSET: data_mem[idx] <= '1;
            OP_WMCLR: wmask_mem[idx] <= 1'b0;
            OP_WMSET: wmask_mem[idx] <= 1'b1;
            OP_BMCLR: bmask_mem[idx] <= '0;
            OP_BMSET: bmask_mem[idx] <= '1;
            OP_CCLR: data_mem[idx] <= data_mem[idx] & ~chan_set;
            OP_CSET: data_mem[idx] <= data_mem[idx] | chan_set;
            OP_CMCLR: bmask_mem[idx] <= bmask_mem[idx] & ~chan_set;
            OP_CMSET: bmask_mem[idx] <= bmask_mem[idx] | chan_set;
            OP_COPY: begin
              data_mem[idx][dst_ch] <= data_mem[idx][src_ch];
              bmask_mem[idx][dst_ch] <= bmask_mem[idx][src_ch];
            end
            OP_XCHG: begin
              // A second exchange of the same pair restores both.
              data_mem[idx][dst_ch] <= data_mem[idx][src_ch];
              data_mem[idx][src_ch] <= data_mem[idx][dst_ch];
              bmask_mem[idx][dst_ch] <= bmask_mem[idx][src_ch];
              bmask_mem[idx][src_ch] <= bmask_mem[idx][dst_ch];
            end
            default: ;
          endcase
        end
        S_INS: begin
          // Top-down copy overwrites the last word first.
          if (idx == line_a) begin
            data_mem[idx] <= '0;
            bmask_mem[idx] <= '0;
            wmask_mem[idx] <= 1'b0;
          end else begin
            data_mem[idx] <= data_mem[idx - ONE_A];
            bmask_mem[idx] <= bmask_mem[idx - ONE_A];
            wmask_mem[idx] <= wmask_mem[idx - ONE_A];
          end
        end
        S_DEL: begin
          if (idx == LAST) begin
            data_mem[idx] <= '0;
            bmask_mem[idx] <= '0;
            wmask_mem[idx] <= 1'b0;
          end else begin
            data_mem[idx] <= data_mem[idx + ONE_A];
            bmask_mem[idx] <= bmask_mem[idx + ONE_A];
            wmask_mem[idx] <= wmask_mem[idx + ONE_A];
          end
        end
        S_REV: begin
          // Swaps keep every word, so the rotation is lossless.
          if (idx < hi) begin
            data_mem[idx] <= data_mem[hi];
            data_mem[hi] <= data_mem[idx];
            bmask_mem[idx] <= bmask_mem[hi];
            bmask_mem[hi] <= bmask_mem[idx];
            wmask_mem[idx] <= wmask_mem[hi];
            wmask_mem[hi] <= wmask_mem[idx];
          end
        end
        default: begin
          if (bus.wr && bus.addr == REG_MDATA) begin
            data_mem[maddr] <= bus.wdata[CH-1:0];
          end
        end
      endcase
    end
  end
  // Compare port: masked bits and words never mismatch.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmp_done <= 1'b0;
      cmp_mismatch <= 1'b0;
    end else begin
      cmp_done <= cmp_valid;
      cmp_mismatch <= cmp_valid && !wmask_mem[cmp_addr]
        && |((cmp_data ^ data_mem[cmp_addr])
             & ~bmask_mem[cmp_addr]);
    end
  end
  // Register reads answer one cycle after the read strobe.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else begin
      rdata <= '0;
      if (bus.rd) begin
        case (bus.addr)
          REG_CMD: rdata[OP_W-1:0] <= pend_op;
          REG_CTRL: rdata[CTRL_CMPMODE] <= cmp_mode;
          REG_CHAN: begin
            rdata[CHAN_SRC_LSB +: CW] <= src_ch;
            rdata[CHAN_DST_LSB +: CW] <= dst_ch;
          end
          REG_STATUS: begin
            rdata[ST_BUSY] <= busy;
            rdata[ST_PEND] <= pend_valid;
            rdata[ST_ERR] <= entry_range_error;
            rdata[ST_CMPMODE] <= cmp_mode;
            rdata[ST_POP_LSB +: OP_W] <= pend_op;
            rdata[ST_COP_LSB +: OP_W] <= op;
          end
          REG_LINE: rdata[AW-1:0] <= line_a;
          REG_ROLL: rdata[AW-1:0] <= roll_a;
          REG_DELAY: rdata[VAL_W-1:0] <= trig_delay;
          REG_MADDR: rdata[AW-1:0] <= maddr;
          REG_MDATA: rdata[CH-1:0] <= data_mem[maddr];
          REG_MWMASK: rdata[0] <= wmask_mem[maddr];
          REG_MBMASK: rdata[CH-1:0] <= bmask_mem[maddr];
          default: begin
            if (bus.addr >= REG_DUP_BASE && int'(dup_idx) < CH) begin
              rdata[CW-1:0] <= dup_of[dup_idx[CW-1:0]];
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire
